// ---- logic/gpio_pkg.sv ----
// shared constants and carrier types for the four-port pin block
package gpio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets in the processor register space
  localparam logic [3:0] FIRST_PORT_VALUE_OFS = 4'h0;
  localparam logic [3:0] SECOND_PORT_VALUE_OFS = 4'h1;
  localparam logic [3:0] THIRD_PORT_VALUE_OFS = 4'h2;
  localparam logic [3:0] FOURTH_PORT_VALUE_OFS = 4'h3;
  localparam logic [3:0] FIRST_PORT_DIRECTION_OFS = 4'h4;
  localparam logic [3:0] SECOND_PORT_DIRECTION_OFS = 4'h5;
  localparam logic [3:0] THIRD_PORT_DIRECTION_OFS = 4'h6;
  localparam logic [3:0] FOURTH_PORT_DIRECTION_OFS = 4'h7;
  localparam logic [3:0] PWM_PIN_SELECT_OFS = 4'ha;
  localparam logic [3:0] SYNC_AND_SERIAL_PIN_SELECT_OFS = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // port widths
  localparam int FIRST_PORT_W = 8;
  localparam int SECOND_PORT_W = 6;
  localparam int THIRD_PORT_W = 8;
  localparam int FOURTH_PORT_W = 2;

  // open-drain pin masks for the dedicated open-drain pins
  localparam logic [5:0] SECOND_PORT_OD_MASK = 6'h3c;
  localparam logic [7:0] THIRD_PORT_OD_MASK = 8'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // field positions in the sync and serial pin select register
  localparam int SERIAL_DATA_SEL_POS = 0;
  localparam int SERIAL_CLOCK_SEL_POS = 1;
  localparam int VERTICAL_TTL_SEL_POS = 6;
  localparam int HORIZONTAL_TTL_SEL_POS = 7;

  // reset values
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] PIN_SELECT_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic SERIAL_IDLE_LEVEL = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // one processor register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : gpio_pkg

// ---- logic/gpio_pin_bank.sv ----
// one port of pins: direction, alternate function, open-drain and read path
`timescale 1ns/1ps
module gpio_pin_bank #(
  parameter int W = 8,
  parameter logic [W-1:0] OD_MASK = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] latch_i,   // output data latch
  input wire logic [W-1:0] dir_i,     // 1 = output
  input wire logic [W-1:0] alt_en_i,  // pin handed to another function
  input wire logic [W-1:0] alt_val_i, // level wanted by that function
  input wire logic [W-1:0] alt_od_i,  // that function drives open-drain
  input wire logic [W-1:0] pin_i,     // pin level
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o,
  output logic [W-1:0] rd_val_o       // value seen by a data read
);

  logic [W-1:0] out_d; // next pin output
  logic [W-1:0] oe_d;  // next pin enable

  ////////////////////////////////////////////////////////////////////////////
  // per-pin drive decision
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic val;   // level to present
    logic drive; // pin is driven at all
    logic od;    // pin only pulls low
    assign val = alt_en_i[i] ? alt_val_i[i] : latch_i[i];
    // R13 alternate function overrides direction
    assign drive = alt_en_i[i] | dir_i[i];
    // R11 dedicated open-drain pins only pull low
    assign od = OD_MASK[i] | (alt_en_i[i] & alt_od_i[i]);
    assign oe_d[i] = drive & (od ? ~val : 1'b1);
    assign out_d[i] = drive & ~od & val;
    // R12 output reads latch, input reads pin
    assign rd_val_o[i] = dir_i[i] ? latch_i[i] : pin_i[i];
  end

  // registered pin drive, released during reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o <= out_d;
      pin_oe_o <= oe_d;
    end
  end

endmodule : gpio_pin_bank

// ---- logic/third_port_select.sv ----
// function choice for the third port pins shared with pwm and sync outputs
`timescale 1ns/1ps
module third_port_select (
  input wire logic [7:0] pwm_sel_i,  // pwm pin select register
  input wire logic [1:0] ttl_sel_i,  // {horizontal, vertical} ttl select
  input wire logic [7:0] pwm_i,      // pwm channels 8 to 15
  input wire logic [1:0] ttl_i,      // {horizontal, vertical} ttl levels
  output logic [7:0] alt_en_o,
  output logic [7:0] alt_val_o
);

  // R08 pins 0 to 5 carry pwm channels 8 to 13
  assign alt_en_o[5:0] = pwm_sel_i[5:0];
  assign alt_val_o[5:0] = pwm_i[5:0];

  // R09 pins 6 and 7 carry sync ttl or pwm 14 and 15
  for (genvar i = 0; i < 2; i++) begin : g_shared
    assign alt_en_o[6+i] = ttl_sel_i[i] | pwm_sel_i[6+i];
    // R14 ttl select wins over pwm select
    assign alt_val_o[6+i] = ttl_sel_i[i] ? ttl_i[i] : pwm_i[6+i];
  end

endmodule : third_port_select

// ---- logic/gpio_four_port.sv ----
// four parallel ports with per-bit direction and pin sharing
// Summary of operation
// R01: 24 lines, each bit's direction selectable
// R02: first port 8 bits, data 0x00, direction 0x04
// R03: second port 6 bits, data 0x01, direction 0x05
// R04: third port 8 bits, data 0x02, direction 0x06
// R05: fourth port 2 bits, data 0x03, direction 0x07
// R06: reset clears directions, keeps data latches
// R07: direction one means output, zero input
// R08: third port pins 0-5 become pwm 8-13
// R09: third port pins 6-7 sync ttl or pwm
// R10: fourth port pins become serial lines, open-drain
// R11: listed pins open-drain, never drive high
// R12: read gives latch for outputs, pin otherwise
// R13: pin select overrides direction bit
// R14: ttl select beats pwm 14 and 15
// R15: both pin select registers reset to zero
// R16: data writes always update the output latch
`timescale 1ns/1ps
module gpio_four_port (
  input wire logic CLK_I,
  input wire logic RST_I,
  // processor register port
  input wire logic [3:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  // first port pins
  input wire logic [7:0] FIRST_PORT_PINS_I,
  output logic [7:0] FIRST_PORT_PINS_O,
  output logic [7:0] FIRST_PORT_PINS_OE_O,
  // second port pins
  input wire logic [5:0] SECOND_PORT_PINS_I,
  output logic [5:0] SECOND_PORT_PINS_O,
  output logic [5:0] SECOND_PORT_PINS_OE_O,
  // third port pins
  input wire logic [7:0] THIRD_PORT_PINS_I,
  output logic [7:0] THIRD_PORT_PINS_O,
  output logic [7:0] THIRD_PORT_PINS_OE_O,
  // fourth port pins
  input wire logic [1:0] FOURTH_PORT_PINS_I,
  output logic [1:0] FOURTH_PORT_PINS_O,
  output logic [1:0] FOURTH_PORT_PINS_OE_O,
  // levels from the shared functions
  input wire logic [7:0] PWM_CH8_15_I,
  input wire logic VERTICAL_TTL_I,
  input wire logic HORIZONTAL_TTL_I,
  input wire logic SERIAL_DATA_DRIVE_I,
  input wire logic SERIAL_CLOCK_DRIVE_I,
  // serial line levels back to the serial block
  output logic SERIAL_DATA_LEVEL_O,
  output logic SERIAL_CLOCK_LEVEL_O
);

  ////////////////////////////////////////////////////////////////////////////
  // local widths

  localparam int AW = gpio_pkg::FIRST_PORT_W;  // first port width
  localparam int BW = gpio_pkg::SECOND_PORT_W; // second port width
  localparam int CW = gpio_pkg::THIRD_PORT_W;  // third port width
  localparam int DW = gpio_pkg::FOURTH_PORT_W; // fourth port width

  ////////////////////////////////////////////////////////////////////////////
  // address decode helper

  // true when a request addresses the given offset
  function automatic logic hits(input gpio_pkg::reg_req_t r, input logic [3:0] ofs);
    hits = (r.addr == ofs);
  endfunction : hits

  ////////////////////////////////////////////////////////////////////////////
  // request bundle

  gpio_pkg::reg_req_t req; // current access

  // gather the register port into one carrier
  assign req.wr = WR_I;
  assign req.rd = RD_I;
  assign req.addr = ADDR_I;
  assign req.wdata = WDATA_I;

  ////////////////////////////////////////////////////////////////////////////
  // output data latches

  logic [AW-1:0] first_port_value_q;  // first port latch, no reset
  logic [BW-1:0] second_port_value_q; // second port latch, no reset
  logic [CW-1:0] third_port_value_q;  // third port latch, no reset
  logic [DW-1:0] fourth_port_value_q; // fourth port latch, no reset

  // R06 latches keep their contents through reset
  // R16 write lands in latch regardless of direction
  always_ff @(posedge CLK_I) begin
    // R02 first port data at its offset
    if (req.wr && hits(req, gpio_pkg::FIRST_PORT_VALUE_OFS)) begin
      first_port_value_q <= req.wdata[AW-1:0];
    end
    // R03 second port data at its offset
    if (req.wr && hits(req, gpio_pkg::SECOND_PORT_VALUE_OFS)) begin
      second_port_value_q <= req.wdata[BW-1:0];
    end
    // R04 third port data at its offset
    if (req.wr && hits(req, gpio_pkg::THIRD_PORT_VALUE_OFS)) begin
      third_port_value_q <= req.wdata[CW-1:0];
    end
    // R05 fourth port data at its offset
    if (req.wr && hits(req, gpio_pkg::FOURTH_PORT_VALUE_OFS)) begin
      fourth_port_value_q <= req.wdata[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers

  logic [AW-1:0] first_port_direction_q;  // 1 = output
  logic [BW-1:0] second_port_direction_q; // 1 = output
  logic [CW-1:0] third_port_direction_q;  // 1 = output
  logic [DW-1:0] fourth_port_direction_q; // 1 = output

  // R01 one direction bit per pin
  // R07 a one makes the pin an output
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      // R06 reset turns every pin into an input
      first_port_direction_q <= gpio_pkg::DIRECTION_RESET[AW-1:0];
      second_port_direction_q <= gpio_pkg::DIRECTION_RESET[BW-1:0];
      third_port_direction_q <= gpio_pkg::DIRECTION_RESET[CW-1:0];
      fourth_port_direction_q <= gpio_pkg::DIRECTION_RESET[DW-1:0];
    end else if (req.wr) begin
      // R02 first port direction at its offset
      if (hits(req, gpio_pkg::FIRST_PORT_DIRECTION_OFS)) begin
        first_port_direction_q <= req.wdata[AW-1:0];
      end
      // R03 second port direction at its offset
      if (hits(req, gpio_pkg::SECOND_PORT_DIRECTION_OFS)) begin
        second_port_direction_q <= req.wdata[BW-1:0];
      end
      // R04 third port direction at its offset
      if (hits(req, gpio_pkg::THIRD_PORT_DIRECTION_OFS)) begin
        third_port_direction_q <= req.wdata[CW-1:0];
      end
      // R05 fourth port direction at its offset
      if (hits(req, gpio_pkg::FOURTH_PORT_DIRECTION_OFS)) begin
        fourth_port_direction_q <= req.wdata[DW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin select registers

  logic [7:0] pwm_pin_select_q;     // pwm channel 8 to 15 pin select
  logic [1:0] ttl_pin_select_q;     // {horizontal, vertical} ttl select
  logic [1:0] serial_pin_select_q;  // {clock, data} serial select

  // R15 both select registers start at zero
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pwm_pin_select_q <= gpio_pkg::PIN_SELECT_RESET;
      ttl_pin_select_q <= gpio_pkg::PIN_SELECT_RESET[1:0];
      serial_pin_select_q <= gpio_pkg::PIN_SELECT_RESET[1:0];
    end else if (req.wr) begin
      // R08 pwm select written at its offset
      if (hits(req, gpio_pkg::PWM_PIN_SELECT_OFS)) begin
        pwm_pin_select_q <= req.wdata;
      end
      // R10 sync and serial select at its offset
      if (hits(req, gpio_pkg::SYNC_AND_SERIAL_PIN_SELECT_OFS)) begin
        ttl_pin_select_q[0] <= req.wdata[gpio_pkg::VERTICAL_TTL_SEL_POS];
        ttl_pin_select_q[1] <= req.wdata[gpio_pkg::HORIZONTAL_TTL_SEL_POS];
        serial_pin_select_q[0] <= req.wdata[gpio_pkg::SERIAL_DATA_SEL_POS];
        serial_pin_select_q[1] <= req.wdata[gpio_pkg::SERIAL_CLOCK_SEL_POS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate function routing

  logic [CW-1:0] third_alt_en;  // third port pins taken by pwm or ttl
  logic [CW-1:0] third_alt_val; // levels from pwm or ttl
  logic [DW-1:0] fourth_alt_val; // serial drive levels

  // R09 third port function choice with ttl priority
  // R14 ttl select overrides pwm 14 and 15
  third_port_select u_third_sel (
    .pwm_sel_i(pwm_pin_select_q),
    .ttl_sel_i(ttl_pin_select_q),
    .pwm_i(PWM_CH8_15_I),
    .ttl_i({HORIZONTAL_TTL_I, VERTICAL_TTL_I}),
    .alt_en_o(third_alt_en),
    .alt_val_o(third_alt_val)
  );

  // serial block pulls a line low with a zero, releases it with a one
  assign fourth_alt_val = {SERIAL_CLOCK_DRIVE_I, SERIAL_DATA_DRIVE_I};

  ////////////////////////////////////////////////////////////////////////////
  // pin banks

  logic [AW-1:0] first_rd;  // first port read value
  logic [BW-1:0] second_rd; // second port read value
  logic [CW-1:0] third_rd;  // third port read value
  logic [DW-1:0] fourth_rd; // fourth port read value

  // first port: plain push-pull pins
  gpio_pin_bank #(
    .W(AW),
    .OD_MASK('0)
  ) u_first (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .latch_i(first_port_value_q),
    .dir_i(first_port_direction_q),
    .alt_en_i('0),
    .alt_val_i('0),
    .alt_od_i('0),
    .pin_i(FIRST_PORT_PINS_I),
    .pin_o(FIRST_PORT_PINS_O),
    .pin_oe_o(FIRST_PORT_PINS_OE_O),
    .rd_val_o(first_rd)
  );

  // R11 second port pins 2 to 5 open-drain
  gpio_pin_bank #(
    .W(BW),
    .OD_MASK(gpio_pkg::SECOND_PORT_OD_MASK)
  ) u_second (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .latch_i(second_port_value_q),
    .dir_i(second_port_direction_q),
    .alt_en_i('0),
    .alt_val_i('0),
    .alt_od_i('0),
    .pin_i(SECOND_PORT_PINS_I),
    .pin_o(SECOND_PORT_PINS_O),
    .pin_oe_o(SECOND_PORT_PINS_OE_O),
    .rd_val_o(second_rd)
  );

  // R11 third port pins 0 to 5 open-drain
  // R13 selected functions drive whatever the direction
  gpio_pin_bank #(
    .W(CW),
    .OD_MASK(gpio_pkg::THIRD_PORT_OD_MASK)
  ) u_third (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .latch_i(third_port_value_q),
    .dir_i(third_port_direction_q),
    .alt_en_i(third_alt_en),
    .alt_val_i(third_alt_val),
    .alt_od_i('0),
    .pin_i(THIRD_PORT_PINS_I),
    .pin_o(THIRD_PORT_PINS_O),
    .pin_oe_o(THIRD_PORT_PINS_OE_O),
    .rd_val_o(third_rd)
  );

  // R10 serial lines drive open-drain only
  gpio_pin_bank #(
    .W(DW),
    .OD_MASK('0)
  ) u_fourth (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .latch_i(fourth_port_value_q),
    .dir_i(fourth_port_direction_q),
    .alt_en_i(serial_pin_select_q),
    .alt_val_i(fourth_alt_val),
    .alt_od_i('1),
    .pin_i(FOURTH_PORT_PINS_I),
    .pin_o(FOURTH_PORT_PINS_O),
    .pin_oe_o(FOURTH_PORT_PINS_OE_O),
    .rd_val_o(fourth_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial line levels

  // pin levels handed back; idle high while not selected or in reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SERIAL_DATA_LEVEL_O <= gpio_pkg::SERIAL_IDLE_LEVEL;
      SERIAL_CLOCK_LEVEL_O <= gpio_pkg::SERIAL_IDLE_LEVEL;
    end else begin
      SERIAL_DATA_LEVEL_O <= serial_pin_select_q[0] ? FOURTH_PORT_PINS_I[0]
                                                    : gpio_pkg::SERIAL_IDLE_LEVEL;
      SERIAL_CLOCK_LEVEL_O <= serial_pin_select_q[1] ? FOURTH_PORT_PINS_I[1]
                                                     : gpio_pkg::SERIAL_IDLE_LEVEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rd_d; // read value for the addressed register

  // register read mux; unused bits and unmapped offsets read zero
  always_comb begin
    rd_d = gpio_pkg::READ_IDLE;
    case (req.addr)
      // R12 data reads follow the direction bit
      gpio_pkg::FIRST_PORT_VALUE_OFS: begin
        rd_d = first_rd;
      end
      gpio_pkg::SECOND_PORT_VALUE_OFS: begin
        rd_d[BW-1:0] = second_rd;
      end
      gpio_pkg::THIRD_PORT_VALUE_OFS: begin
        rd_d = third_rd;
      end
      gpio_pkg::FOURTH_PORT_VALUE_OFS: begin
        rd_d[DW-1:0] = fourth_rd;
      end
      // direction registers read back as written
      gpio_pkg::FIRST_PORT_DIRECTION_OFS: begin
        rd_d = first_port_direction_q;
      end
      gpio_pkg::SECOND_PORT_DIRECTION_OFS: begin
        rd_d[BW-1:0] = second_port_direction_q;
      end
      gpio_pkg::THIRD_PORT_DIRECTION_OFS: begin
        rd_d = third_port_direction_q;
      end
      gpio_pkg::FOURTH_PORT_DIRECTION_OFS: begin
        rd_d[DW-1:0] = fourth_port_direction_q;
      end
      // pin select registers
      gpio_pkg::PWM_PIN_SELECT_OFS: begin
        rd_d = pwm_pin_select_q;
      end
      gpio_pkg::SYNC_AND_SERIAL_PIN_SELECT_OFS: begin
        rd_d[gpio_pkg::VERTICAL_TTL_SEL_POS] = ttl_pin_select_q[0];
        rd_d[gpio_pkg::HORIZONTAL_TTL_SEL_POS] = ttl_pin_select_q[1];
        rd_d[gpio_pkg::SERIAL_DATA_SEL_POS] = serial_pin_select_q[0];
        rd_d[gpio_pkg::SERIAL_CLOCK_SEL_POS] = serial_pin_select_q[1];
      end
      // unmapped offset
      default: begin
        rd_d = gpio_pkg::READ_IDLE;
      end
    endcase
  end

  // read data captured on a read strobe, held until the next one
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= gpio_pkg::READ_IDLE;
    end else if (req.rd) begin
      RDATA_O <= rd_d;
    end
  end

endmodule : gpio_four_port

// ---- dv/gpio_four_port_monitor.sv ----
// assertion checker for the four-port pin block
`timescale 1ns/1ps
module gpio_four_port_monitor (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [7:0] FIRST_PORT_PINS_OE_O,
  input wire logic [5:0] SECOND_PORT_PINS_O,
  input wire logic [7:0] THIRD_PORT_PINS_O,
  input wire logic [7:0] THIRD_PORT_PINS_OE_O,
  input wire logic [1:0] FOURTH_PORT_PINS_O,
  input wire logic [1:0] FOURTH_PORT_PINS_OE_O,
  input wire logic [7:0] PWM_CH8_15_I,
  input wire logic HORIZONTAL_TTL_I,
  input wire logic SERIAL_DATA_DRIVE_I,
  input wire logic SERIAL_CLOCK_LEVEL_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  ////////////////////////////////////////////////////////////////////////////
  // write strobes decoded per offset
  wire wr_dir_a = WR_I && (ADDR_I == 4'h4);
  wire wr_cfg1 = WR_I && (ADDR_I == 4'ha);
  wire wr_cfg2 = WR_I && (ADDR_I == 4'hb);

  ////////////////////////////////////////////////////////////////////////////
  // reset must be seen even while it is active, so no disable here
  AST_RESET_RELEASE: assert property (disable iff (1'b0)
    RST_I |=> ((FIRST_PORT_PINS_OE_O | THIRD_PORT_PINS_OE_O) == 8'h00)
      && (FOURTH_PORT_PINS_OE_O == 2'b00) && (RDATA_O == 8'h00))
    else $error("pins driven or read data set after reset");
  AST_DIR_TO_OE: assert property (
    wr_dir_a ##1 !wr_dir_a |=> FIRST_PORT_PINS_OE_O == $past(WDATA_I, 2))
    else $error("first port enables differ from written direction");
  AST_OD_NEVER_HIGH: assert property (
    (SECOND_PORT_PINS_O[5:2] == 4'h0) && (THIRD_PORT_PINS_O[5:0] == 6'h00))
    else $error("open-drain pin driven high");
  AST_RDATA_HOLD: assert property (
    !RD_I |=> $stable(RDATA_O))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (
    RD_I && (ADDR_I inside {4'h8, 4'h9} || ADDR_I > 4'hb) |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  AST_UNUSED_BITS: assert property (
    RD_I && (ADDR_I == 4'h5) |=> RDATA_O[7:6] == 2'b00)
    else $error("unused direction bits read non-zero");
  AST_SERIAL_OPEN_DRAIN: assert property (
    (wr_cfg2 && WDATA_I[0]) ##1 !WR_I [*3] |-> (FOURTH_PORT_PINS_O[0] == 1'b0)
      && (FOURTH_PORT_PINS_OE_O[0] == !$past(SERIAL_DATA_DRIVE_I)))
    else $error("serial data pin not open-drain from its drive");
  AST_TTL_OVER_PWM: assert property (
    (wr_cfg2 && WDATA_I[7]) ##1 !WR_I [*3] |-> THIRD_PORT_PINS_OE_O[7]
      && (THIRD_PORT_PINS_O[7] == $past(HORIZONTAL_TTL_I)))
    else $error("third port pin 7 not following ttl level");
  AST_PWM_PIN: assert property (
    (wr_cfg1 && WDATA_I[0]) ##1 !WR_I [*3] |->
      THIRD_PORT_PINS_OE_O[0] == !$past(PWM_CH8_15_I[0]))
    else $error("third port pin 0 not following pwm channel 8");
  AST_SERIAL_LEVEL_IDLE: assert property (
    (wr_cfg2 && !WDATA_I[1]) ##1 !WR_I [*3] |-> SERIAL_CLOCK_LEVEL_O)
    else $error("serial clock level not idle while unselected");

  // main scenarios reached
  CVR_TTL: cover property (wr_cfg2 && WDATA_I[7]);
  CVR_PWM: cover property (wr_cfg1 && WDATA_I[0]);
  CVR_REREST: cover property (disable iff (1'b0) RST_I ##1 !RST_I);
endmodule : gpio_four_port_monitor

bind gpio_four_port gpio_four_port_monitor mon (
  .CLK_I, .RST_I, .ADDR_I, .WR_I, .RD_I, .WDATA_I, .RDATA_O, .FIRST_PORT_PINS_OE_O,
  .SECOND_PORT_PINS_O, .THIRD_PORT_PINS_O, .THIRD_PORT_PINS_OE_O, .FOURTH_PORT_PINS_O,
  .FOURTH_PORT_PINS_OE_O, .PWM_CH8_15_I, .HORIZONTAL_TTL_I, .SERIAL_DATA_DRIVE_I,
  .SERIAL_CLOCK_LEVEL_O);

// ---- dv/pin_board_model.sv ----
// board model of the 24 port pins: pull-ups and optional outside drivers
`timescale 1ns/1ps
module pin_board_model (
  input wire logic [23:0] drv_i,
  input wire logic [23:0] oe_i,
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_val_i,
  output logic [23:0] lvl_o
);
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (oe_i[i]) begin
        lvl_o[i] = drv_i[i];
      end else if (ext_en_i[i]) begin
        lvl_o[i] = ext_val_i[i];
      end else begin
        lvl_o[i] = 1'b1;
      end
    end
  end
endmodule : pin_board_model

// ---- dv/tb_top.sv ----
// self-checking bench for the four-port pin block
`timescale 1ns/1ps
module tb_top;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [7:0] WDATA_I = 8'h00;
  logic [7:0] RDATA_O;
  wire [23:0] pin_o, pin_oe, pin_lvl; // ports a, b, c, d packed from bit 0
  logic [23:0] ext_en = 24'h000000;
  logic [23:0] ext_val = 24'h000000;
  logic [7:0] pwm = 8'h00;
  logic [3:0] aux = 4'h0; // vertical, horizontal, serial data, serial clock
  logic sda_lvl, scl_lvl;
  int error_cnt = 0;
  int total_checks = 0;
  int lat[4], dir[4], sel1, sel2, a;
  int w[4] = '{8, 6, 8, 2};
  int odm[4] = '{0, 'h3c, 'h3f, 0};
  int base[4] = '{0, 8, 14, 22};

  gpio_four_port dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
    .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
    .FIRST_PORT_PINS_I(pin_lvl[7:0]), .FIRST_PORT_PINS_O(pin_o[7:0]),
    .FIRST_PORT_PINS_OE_O(pin_oe[7:0]), .SECOND_PORT_PINS_I(pin_lvl[13:8]),
    .SECOND_PORT_PINS_O(pin_o[13:8]), .SECOND_PORT_PINS_OE_O(pin_oe[13:8]),
    .THIRD_PORT_PINS_I(pin_lvl[21:14]), .THIRD_PORT_PINS_O(pin_o[21:14]),
    .THIRD_PORT_PINS_OE_O(pin_oe[21:14]), .FOURTH_PORT_PINS_I(pin_lvl[23:22]),
    .FOURTH_PORT_PINS_O(pin_o[23:22]), .FOURTH_PORT_PINS_OE_O(pin_oe[23:22]),
    .PWM_CH8_15_I(pwm), .VERTICAL_TTL_I(aux[0]), .HORIZONTAL_TTL_I(aux[1]),
    .SERIAL_DATA_DRIVE_I(aux[2]), .SERIAL_CLOCK_DRIVE_I(aux[3]),
    .SERIAL_DATA_LEVEL_O(sda_lvl), .SERIAL_CLOCK_LEVEL_O(scl_lvl));

  pin_board_model board (.drv_i(pin_o), .oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .lvl_o(pin_lvl));

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 CLK_I = ~CLK_I;
  end

  // expected {enable, value} of one pin
  function automatic logic [1:0] exp_pin(int p, int i);
    int en, od;
    logic val, v;
    od = (odm[p] >> i) & 1;
    en = 0;
    val = 1'b0;
    if (p == 2) begin
      en = (sel1 >> i) & 1;
      val = pwm[i];
      if (i > 5 && ((sel2 >> i) & 1)) begin
        en = 1;
        val = aux[i - 6];
      end
    end
    if (p == 3) begin
      en = (sel2 >> i) & 1;
      val = aux[i + 2];
      od = en;
    end
    v = en ? val : 1'((lat[p] >> i) & 1);
    if (!(en || ((dir[p] >> i) & 1))) return 2'b00;
    return od ? {~v, 1'b0} : {1'b1, v};
  endfunction : exp_pin

  // expected level on the wire
  function automatic logic exp_lvl(int p, int i);
    logic [1:0] d;
    d = exp_pin(p, i);
    if (d[1]) return d[0];
    return ext_en[base[p] + i] ? ext_val[base[p] + i] : 1'b1;
  endfunction : exp_lvl

  // expected register read
  function automatic logic [7:0] mread(int r);
    logic [7:0] v;
    v = 8'h00;
    if (r < 4) begin
      for (int i = 0; i < w[r]; i++) begin
        v[i] = ((dir[r] >> i) & 1) ? 1'((lat[r] >> i) & 1) : exp_lvl(r, i);
      end
    end else if (r < 8) v = 8'(dir[r - 4]);
    else if (r == 10) v = 8'(sel1);
    else if (r == 11) v = 8'(sel2);
    return v;
  endfunction : mread

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_val(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // one register write, model updated alongside
  task automatic wr(int r, int d);
    @(posedge CLK_I);
    ADDR_I <= 4'(r);
    WDATA_I <= 8'(d);
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    if (r < 4) lat[r] = d & ((1 << w[r]) - 1);
    else if (r < 8) dir[r - 4] = d & ((1 << w[r - 4]) - 1);
    else if (r == 10) sel1 = d & 'hff;
    else if (r == 11) sel2 = d & 'hc3;
  endtask : wr

  task automatic rd(int r, logic [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= 4'(r);
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(negedge CLK_I);
    check_val(RDATA_O, e);
  endtask : rd

  // reset keeps data latches, clears direction and selects
  task automatic do_reset();
    @(posedge CLK_I);
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    dir = '{0, 0, 0, 0};
    sel1 = 0;
    sel2 = 0;
  endtask : do_reset

  // settle, then compare every pin, serial level and register
  task automatic check_all();
    logic [1:0] d;
    int k;
    repeat (3) @(posedge CLK_I);
    @(negedge CLK_I);
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < w[p]; i++) begin
        d = exp_pin(p, i);
        k = base[p] + i;
        check_val(8'({pin_oe[k], pin_oe[k] & pin_o[k]}), 8'({d[1], d[1] & d[0]}));
      end
    end
    check_val(8'(sda_lvl), 8'(sel2[0] ? exp_lvl(3, 0) : 1'b1));
    check_val(8'(scl_lvl), 8'(sel2[1] ? exp_lvl(3, 1) : 1'b1));
    for (int r = 0; r < 16; r++) rd(r, mread(r));
  endtask : check_all

  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge CLK_I);
    error_cnt++;
    complete_run();
  end

  initial begin
    void'($urandom(75));
    // hold the power-on reset for two clock edges
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    check_all();
    for (int p = 0; p < 4; p++) wr(p, $urandom);
    wr(10, 'hff);
    wr(11, 'hc3);
    check_all();
    for (int n = 0; n < 80; n++) begin
      if (n == 40) begin
        do_reset();
        for (int p = 4; p < 8; p++) wr(p, 'hff);
        check_all();
      end
      a = $urandom_range(11);
      wr(a, $urandom);
      @(posedge CLK_I);
      pwm <= 8'($urandom);
      aux <= 4'($urandom);
      ext_en <= 24'($urandom);
      ext_val <= 24'($urandom);
      check_all();
    end
    complete_run();
  end
endmodule : tb_top
